// >>> src/erc_ctrl.sv
// Summary of operation
// - standalone enable with share clear locks standalone
// - standalone reconfig attempt ignored, no failure flag
// - standalone: shunt limit sets overcurrent flag and current limit
// - overcurrent flag sticky, clear needs condition gone
// - standalone: undervoltage detection sets undervoltage flag
// - first share write locks load sharing
// - share locked: reconfig attempt sets spi failure
// - share, no keep bit: off in stop
// - share bit stays; resumes on normal
// - share active normal, stop with keep bit
// - share: undervoltage flag never set
// - share: off in fail-safe
// - share: overcurrent flag never set
// - standalone enable acts only in normal
// - off at supply low unless keep bit
`timescale 1ns/1ps
`default_nettype none
module erc_ctrl
  import erc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      por_rst,
  input  wire logic [2:0] sys_mode,
  input  wire logic      cfg_wr,
  input  wire logic      wr_standalone_enable,
  input  wire logic      wr_load_share_enable,
  input  wire logic      wr_share_keep_in_stop,
  input  wire logic      wr_keep_on_supply_low,
  input  wire logic      oc_clr,
  input  wire logic      uv_clr,
  input  wire logic      shunt_limit_pin,
  input  wire logic      aux_uv_pin,
  input  wire logic      supply_undervoltage_pin,
  output logic           aux_regulator_on_ff,
  output logic           aux_current_limit_ff,
  output logic           aux_standalone_enable_ff,
  output logic           aux_load_share_enable_ff,
  output logic           aux_share_keep_in_stop_ff,
  output logic           aux_keep_on_supply_low_ff,
  output logic           aux_overcurrent_flag_ff,
  output logic           aux_undervoltage_flag_ff,
  output logic           spi_fail_pulse_ff,
  output logic [1:0]     cfg_state_ff
);
  erc_cfg_t  cfg_ff;
  erc_cfg_t  nxt_cfg;
  erc_mode_t mode;
  logic      shunt_s;
  logic      aux_uv_s;
  logic      supply_undervoltage_s;
  logic      alone;
  logic      share;
  logic      oc_set;
  logic      uv_set;
  logic      oc_flag;
  logic      uv_flag;
  logic      nxt_on;
  logic      cfg_change;

  assign mode  = erc_mode_t'(sys_mode);
  assign alone = (cfg_ff == ERC_CFG_ALONE);
  assign share = (cfg_ff == ERC_CFG_SHARE);

  erc_sync u_sync_shunt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (shunt_limit_pin),
    .dout    (shunt_s)
  );

  erc_sync u_sync_auxuv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (aux_uv_pin),
    .dout    (aux_uv_s)
  );

  erc_sync u_sync_vsuv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (supply_undervoltage_pin),
    .dout    (supply_undervoltage_s)
  );

  // configuration lock
  always_comb begin
    nxt_cfg = cfg_ff;
    unique case (cfg_ff)
      ERC_CFG_NONE: begin
        if (cfg_wr && wr_load_share_enable) begin
          nxt_cfg = ERC_CFG_SHARE;
        end else if (cfg_wr && wr_standalone_enable && mode == ERC_MODE_NORMAL) begin
          nxt_cfg = ERC_CFG_ALONE;
        end
      end
      ERC_CFG_ALONE: nxt_cfg = ERC_CFG_ALONE;
      ERC_CFG_SHARE: nxt_cfg = ERC_CFG_SHARE;
      default:       nxt_cfg = ERC_CFG_NONE;
    endcase
  end

  // only power-on reset releases the lock, soft resets do not
  always_ff @(posedge clk) begin
    if (por_rst) begin
      cfg_ff <= ERC_CFG_NONE;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_state_ff <= 2'h0;
    end else begin
      cfg_state_ff <= nxt_cfg;
    end
  end

  // control bits; share bit is never cleared once locked
  always_ff @(posedge clk) begin
    if (por_rst) begin
      aux_load_share_enable_ff <= ERC_EN_RST;
    end else if (nxt_cfg == ERC_CFG_SHARE) begin
      aux_load_share_enable_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_standalone_enable_ff  <= ERC_EN_RST;
      aux_share_keep_in_stop_ff <= ERC_EN_RST;
      aux_keep_on_supply_low_ff <= ERC_EN_RST;
    end else if (cfg_wr) begin
      aux_share_keep_in_stop_ff <= wr_share_keep_in_stop;
      aux_keep_on_supply_low_ff <= wr_keep_on_supply_low;
      // on/off may still change in standalone, only in normal mode
      if (mode == ERC_MODE_NORMAL && nxt_cfg != ERC_CFG_SHARE) begin
        aux_standalone_enable_ff <= wr_standalone_enable;
      end
    end
  end

  // any write that would alter a locked share configuration
  assign cfg_change = cfg_wr && (!wr_load_share_enable || wr_standalone_enable);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spi_fail_pulse_ff <= 1'b0;
    end else begin
      spi_fail_pulse_ff <= share && cfg_change;
    end
  end

  // regulator enable by mode
  always_comb begin
    nxt_on = 1'b0;
    if (alone) begin
      unique case (mode)
        ERC_MODE_INIT, ERC_MODE_FAILSAFE: nxt_on = 1'b0;
        default:                          nxt_on = aux_standalone_enable_ff;
      endcase
    end else if (share) begin
      unique case (mode)
        ERC_MODE_NORMAL, ERC_MODE_RESTART: nxt_on = 1'b1;
        ERC_MODE_STOP:     nxt_on = aux_share_keep_in_stop_ff;
        ERC_MODE_FAILSAFE: nxt_on = 1'b0;
        default:           nxt_on = 1'b0;
      endcase
    end
    if (supply_undervoltage_s && !aux_keep_on_supply_low_ff) begin
      nxt_on = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_regulator_on_ff <= ERC_EN_RST;
    end else begin
      aux_regulator_on_ff <= nxt_on;
    end
  end

  // limiting and the overcurrent flag are the reactions to overcurrent; share mode never limits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_current_limit_ff <= 1'b0;
    end else begin
      aux_current_limit_ff <= alone && aux_regulator_on_ff && shunt_s;
    end
  end

  // a held condition keeps re-setting, so a clear only lands once it is gone
  assign oc_set = alone && aux_regulator_on_ff && shunt_s;
  assign uv_set = alone && aux_regulator_on_ff && aux_uv_s;

  erc_flag u_oc_flag (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set_in  (oc_set),
    .clr_in  (oc_clr),
    .flag_ff (oc_flag)
  );

  erc_flag u_uv_flag (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set_in  (uv_set),
    .clr_in  (uv_clr),
    .flag_ff (uv_flag)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_overcurrent_flag_ff  <= ERC_FLAG_RST;
      aux_undervoltage_flag_ff <= ERC_FLAG_RST;
    end else begin
      aux_overcurrent_flag_ff  <= oc_flag;
      aux_undervoltage_flag_ff <= uv_flag;
    end
  end

endmodule : erc_ctrl
`default_nettype wire

// >>> src/erc_pkg.sv
package erc_pkg;

  // system mode as reported by the mode controller
  typedef enum logic [2:0] {
    ERC_MODE_INIT     = 3'h0,
    ERC_MODE_NORMAL   = 3'h1,
    ERC_MODE_STOP     = 3'h2,
    ERC_MODE_SLEEP    = 3'h3,
    ERC_MODE_RESTART  = 3'h4,
    ERC_MODE_FAILSAFE = 3'h5
  } erc_mode_t;

  // configuration lock state; unset -> standalone flips one bit, unset -> share flips both
  typedef enum logic [1:0] {
    ERC_CFG_NONE  = 2'h0,
    ERC_CFG_ALONE = 2'h1,
    ERC_CFG_SHARE = 2'h3
  } erc_cfg_t;

  localparam logic       ERC_FLAG_RST   = 1'h0;
  localparam logic       ERC_EN_RST     = 1'h0;
  localparam logic [1:0] ERC_SYNC_STAGES = 2'h3;

endpackage : erc_pkg

// >>> src/erc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module erc_sync
  import erc_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // third stage agrees with second before the level moves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout  <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule : erc_sync
`default_nettype wire

// >>> src/erc_flag.sv
`timescale 1ns/1ps
`default_nettype none
module erc_flag
  import erc_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_ff
);
  // set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_ff <= ERC_FLAG_RST;
    end else if (set_in) begin
      flag_ff <= 1'b1;
    end else if (clr_in) begin
      flag_ff <= 1'b0;
    end
  end
endmodule : erc_flag
`default_nettype wire

// >>> tb/erc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module erc_ctrl_props
  import erc_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       por_rst,
  input wire logic [2:0] sys_mode,
  input wire logic       cfg_wr,
  input wire logic       wr_standalone_enable,
  input wire logic       wr_load_share_enable,
  input wire logic       oc_clr,
  input wire logic       shunt_limit_pin,
  input wire logic       supply_undervoltage_pin,
  input wire logic       aux_regulator_on_ff,
  input wire logic       aux_current_limit_ff,
  input wire logic       aux_share_keep_in_stop_ff,
  input wire logic       aux_overcurrent_flag_ff,
  input wire logic       aux_undervoltage_flag_ff,
  input wire logic       spi_fail_pulse_ff,
  input wire logic [1:0] cfg_state_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || por_rst);
  wire logic sh = (cfg_state_ff == 2'h3);
  wire logic sa = (cfg_state_ff == 2'h1);
  AST_LOCK_HOLD: assert property (cfg_state_ff != 2'h0 |=> $stable(cfg_state_ff))
    else $error("lock moved");
  AST_ALONE_QUIET: assert property (sa |-> !spi_fail_pulse_ff)
    else $error("fail in standalone");
  AST_SHARE_FAIL: assert property (sh && cfg_wr && (!wr_load_share_enable ||
    wr_standalone_enable) |=> spi_fail_pulse_ff)
    else $error("no fail pulse");
  AST_OC_SET: assert property ((sa && aux_regulator_on_ff && shunt_limit_pin)[*8]
    |-> aux_overcurrent_flag_ff)
    else $error("oc flag missing");
  AST_OC_HOLD: assert property ($fell(aux_overcurrent_flag_ff)
    |-> $past(oc_clr) || $past(oc_clr, 2) || $past(oc_clr, 3))
    else $error("oc flag fell alone");
  AST_SHARE_NO_OC: assert property (sh |-> !aux_overcurrent_flag_ff && !aux_current_limit_ff)
    else $error("oc in share");
  AST_SHARE_NO_UV: assert property (sh |-> !aux_undervoltage_flag_ff)
    else $error("uv in share");
  AST_STOP_OFF: assert property ((sh && sys_mode == ERC_MODE_STOP && !aux_share_keep_in_stop_ff)[*2]
    |-> !aux_regulator_on_ff)
    else $error("on in stop");
  AST_FS_OFF: assert property ((sh && sys_mode == ERC_MODE_FAILSAFE)[*2] |-> !aux_regulator_on_ff)
    else $error("on in failsafe");
  AST_NORMAL_ON: assert property ((sh && sys_mode == ERC_MODE_NORMAL && !supply_undervoltage_pin)[*8]
    |-> aux_regulator_on_ff)
    else $error("off in normal");
  cover property (sh && spi_fail_pulse_ff);
  cover property ($rose(aux_overcurrent_flag_ff));
  cover property (sh && sys_mode == ERC_MODE_STOP && !aux_regulator_on_ff);
endmodule : erc_ctrl_props
bind erc_ctrl erc_ctrl_props u_props (.clk, .sys_rst, .por_rst, .sys_mode, .cfg_wr,
  .wr_standalone_enable, .wr_load_share_enable, .oc_clr, .shunt_limit_pin,
  .supply_undervoltage_pin, .aux_regulator_on_ff, .aux_current_limit_ff,
  .aux_share_keep_in_stop_ff, .aux_overcurrent_flag_ff, .aux_undervoltage_flag_ff,
  .spi_fail_pulse_ff, .cfg_state_ff);
`default_nettype wire

// >>> tb/tb_erc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_erc_ctrl;
  import erc_pkg::*;
  logic       clk = 1'b0, sys_rst = 1'b1, por_rst = 1'b1, cfg_wr = 1'b0;
  logic [2:0] md = ERC_MODE_NORMAL;
  logic       ws = 1'b0, wl = 1'b0, wk = 1'b0, wv = 1'b0, oc_clr = 1'b0;
  logic       shunt = 1'b0, auv = 1'b0, slow = 1'b0, fseen = 1'b0, uc = 1'b0;
  logic       on, lim, bsa, bls, bk, bv, oc, uv, fail;
  logic [1:0] cfg;
  int         failures = 0, check_count = 0, cycles = 0;
  erc_ctrl dut (.clk, .sys_rst, .por_rst, .sys_mode(md), .cfg_wr,
    .wr_standalone_enable(ws), .wr_load_share_enable(wl), .wr_share_keep_in_stop(wk),
    .wr_keep_on_supply_low(wv), .oc_clr, .uv_clr(uc), .shunt_limit_pin(shunt),
    .aux_uv_pin(auv), .supply_undervoltage_pin(slow), .aux_regulator_on_ff(on),
    .aux_current_limit_ff(lim), .aux_standalone_enable_ff(bsa), .aux_load_share_enable_ff(bls),
    .aux_share_keep_in_stop_ff(bk), .aux_keep_on_supply_low_ff(bv), .aux_overcurrent_flag_ff(oc),
    .aux_undervoltage_flag_ff(uv), .spi_fail_pulse_ff(fail), .cfg_state_ff(cfg));
  always #5 clk = ~clk;
  // pulse lasts one cycle, set on the edge that samples the strobe, so it is latched here
  always @(negedge clk) if (fail === 1'b1) fseen <= 1'b1;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %b exp %b", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic s, input logic l, input logic k);
    fseen = 1'b0;
    cfg_wr = 1'b1;
    ws = s;
    wl = l;
    wk = k;
    @(negedge clk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic clr_oc;
    oc_clr = 1'b1;
    @(negedge clk);
    oc_clr = 1'b0;
    wt(4);
  endtask : clr_oc
  task report_and_stop;
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    wt(5);
    sys_rst = 1'b0;
    por_rst = 1'b0;
    wr(1'b1, 1'b0, 1'b0);
    chk(cfg, 2'h1);
    chk({bsa, on}, 2'h3);
    wr(1'b0, 1'b1, 1'b0);
    chk(cfg, 2'h1);
    chk({1'b0, fseen}, 2'h0);
    wr(1'b1, 1'b0, 1'b0);
    shunt = 1'b1;
    wt(10);
    chk({oc, lim}, 2'h3);
    clr_oc();
    chk({1'b0, oc}, 2'h1);
    shunt = 1'b0;
    wt(8);
    clr_oc();
    chk({1'b0, oc}, 2'h0);
    auv = 1'b1;
    wt(10);
    chk({1'b0, uv}, 2'h1);
    auv = 1'b0;
    wt(8);
    uc = 1'b1;
    wt(1);
    uc = 1'b0;
    wt(2);
    chk({1'b0, uv}, 2'h0);
    md = ERC_MODE_STOP;
    wr(1'b0, 1'b0, 1'b0);
    chk({1'b0, on}, 2'h1);
    md = ERC_MODE_NORMAL;
    slow = 1'b1;
    wt(10);
    chk({1'b0, on}, 2'h0);
    slow = 1'b0;
    wt(10);
    chk({1'b0, on}, 2'h1);
    sys_rst = 1'b1;
    wt(2);
    sys_rst = 1'b0;
    wt(2);
    chk(cfg, 2'h1);
    por_rst = 1'b1;
    sys_rst = 1'b1;
    wt(2);
    por_rst = 1'b0;
    sys_rst = 1'b0;
    wr(1'b0, 1'b1, 1'b0);
    chk(cfg, 2'h3);
    chk({bls, on}, 2'h3);
    wr(1'b0, 1'b0, 1'b0);
    chk({fseen, bls}, 2'h3);
    wr(1'b1, 1'b1, 1'b0);
    chk({fseen, cfg[0]}, 2'h3);
    shunt = 1'b1;
    auv = 1'b1;
    md = ERC_MODE_STOP;
    wt(10);
    chk({on, bls}, 2'h1);
    chk({oc, uv}, 2'h0);
    md = ERC_MODE_NORMAL;
    wt(4);
    chk({1'b0, on}, 2'h1);
    wv = 1'b1;
    wr(1'b0, 1'b1, 1'b1);
    chk({bk, bv}, 2'h3);
    md = ERC_MODE_STOP;
    wt(4);
    chk({fseen, on}, 2'h1);
    slow = 1'b1;
    wt(10);
    chk({1'b0, on}, 2'h1);
    slow = 1'b0;
    md = ERC_MODE_FAILSAFE;
    wt(4);
    chk({1'b0, on}, 2'h0);
    report_and_stop();
  end
endmodule : tb_erc_ctrl
`default_nettype wire
